// File: design/trig_disp_pkg.sv
// Package: register map, field codes, reset values and timing for trigger/display block
package trig_disp_pkg;

  // Register byte offsets (word aligned)
  localparam logic [7:0] ADDR_TRIG_CFG   = 8'h00;
  localparam logic [7:0] ADDR_DIG_OUT    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_DISP_CFG   = 8'h0C;
  localparam logic [7:0] ADDR_STEP       = 8'h10;
  localparam logic [7:0] ADDR_PERSIST    = 8'h14;
  localparam logic [7:0] ADDR_DRIVE      = 8'h18;

  // Trigger mode codes
  typedef enum logic [2:0] {
    TRIG_DISABLED  = 3'h0,
    TRIG_DIG_IN    = 3'h1,
    TRIG_STEP_UP   = 3'h2,
    TRIG_STEP_DOWN = 3'h3,
    TRIG_DIG_OUT   = 3'h4
  } trig_mode_t;

  // Trigger config field positions: port one low byte, port two next
  localparam int TRIG_MODE_LSB  = 0;
  localparam int TRIG_POL_BIT   = 3;
  localparam int TRIG_PORT_SPAN = 8;

  // Display config field positions
  localparam int DISP_ACTIVE_LSB  = 0;
  localparam int DISP_IDLE_LSB    = 8;
  localparam int DISP_TIMEOUT_LSB = 16;

  // Limits
  localparam logic [6:0] BRIGHT_MAX      = 7'h64;  // 100
  localparam logic [6:0] BRIGHT_MIN_LIT  = 7'h01;
  localparam logic [3:0] IDLE_MAX        = 4'hA;   // 10
  localparam logic [8:0] TIMEOUT_MAX     = 9'h1E0; // 480 minutes

  // Reset values
  localparam logic [15:0] TRIG_CFG_RST    = 16'h0000;
  localparam logic [6:0]  ACTIVE_RST      = 7'h3C;
  localparam logic [3:0]  IDLE_RST        = 4'h2;
  localparam logic [8:0]  TIMEOUT_RST     = 9'h00A;
  localparam logic [15:0] STEP_RST        = 16'h0001;
  localparam logic [15:0] DRIVE_RST       = 16'h0000;

  // Timing: one minute in sys_clk cycles at 125 MHz
  localparam longint CLK_HZ        = 125000000;
  localparam longint MINUTE_S      = 60;
  localparam longint MINUTE_CYCLES = CLK_HZ * MINUTE_S;

endpackage

// File: design/trig_disp_top.sv
// Trigger ports and display dimmer with a classic Wishbone register slave
//
// Chosen here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module trig_disp_top
  import trig_disp_pkg::*;
#(
  parameter longint MINUTE_CYCLES_P = trig_disp_pkg::MINUTE_CYCLES
)
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Trigger pins
  input  wire logic        trigger_port_one_in,
  output logic             trigger_port_one_out,
  output logic             trigger_port_one_oe,
  input  wire logic        trigger_port_two_in,
  output logic             trigger_port_two_out,
  output logic             trigger_port_two_oe,
  // Unit state and panel
  input  wire logic        open_loop,
  input  wire logic        host_boot,
  input  wire logic        menu_key,
  input  wire logic        panel_activity,
  input  wire logic        position_view,
  // Nonvolatile store image
  input  wire logic        nv_valid,
  input  wire logic [15:0] nv_trig_cfg,
  input  wire logic [15:0] nv_step,
  output logic             nv_write,
  output logic [15:0]      nv_trig_cfg_out,
  output logic [15:0]      nv_step_out,
  // Results
  output logic [15:0]      drive_level,
  output logic [6:0]       disp_level,
  output logic             disp_dimmed
);
  import trig_disp_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] trig_cfg_reg;
  logic [1:0]  dig_out_reg;
  logic [6:0]  active_reg;
  logic [3:0]  idle_reg;
  logic [8:0]  timeout_reg;
  logic [15:0] step_reg;
  logic [15:0] drive_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic        nv_write_reg;
  logic        boot_done_reg;
  logic        wake_reg;
  logic        dimmed_reg;
  logic        menu_prev_reg;
  logic [6:0]  disp_reg;
  logic [32:0] tick_cnt_reg; // One minute at full clock rate needs 33 bits
  logic [8:0]  min_cnt_reg;

  // Clamp helper used for several limited fields
  function automatic logic [8:0] clamp9(input logic [8:0] v, input logic [8:0] lim);
    clamp9 = (v > lim) ? lim : v;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Ack gates the take, so a request held across its ack is taken only once
  wire bus_req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire bus_wr    = bus_req & wb_we_i;
  wire wr_trig   = bus_wr & (wb_adr_i == ADDR_TRIG_CFG);
  wire wr_dout   = bus_wr & (wb_adr_i == ADDR_DIG_OUT) & wb_sel_i[0];
  wire wr_disp   = bus_wr & (wb_adr_i == ADDR_DISP_CFG);
  wire wr_step   = bus_wr & (wb_adr_i == ADDR_STEP);
  wire wr_pers   = bus_wr & (wb_adr_i == ADDR_PERSIST) & wb_sel_i[0] & wb_dat_i[0];
  wire wr_drive  = bus_wr & (wb_adr_i == ADDR_DRIVE);
  // Unselected byte lanes write as zero in trigger config, step and drive; display fields on them keep their value
  wire [15:0] wdat16 = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                        wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00};

  // ----------------------------------------------------------------
  // Trigger ports
  // ----------------------------------------------------------------
  trig_mode_t mode_one;
  trig_mode_t mode_two;
  logic       st_one;
  logic       st_two;
  logic       up_one;
  logic       up_two;
  logic       dn_one;
  logic       dn_two;

  // Mode sits in the low three bits of each port byte
  assign mode_one = trig_mode_t'(trig_cfg_reg[TRIG_MODE_LSB +: 3]);
  assign mode_two = trig_mode_t'(trig_cfg_reg[TRIG_PORT_SPAN + TRIG_MODE_LSB +: 3]);

  trig_port u_port_one (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .mode      (mode_one),
    .pol_low   (trig_cfg_reg[TRIG_POL_BIT]),
    .out_level (dig_out_reg[0]),
    .pin_in    (trigger_port_one_in),
    .pin_out   (trigger_port_one_out),
    .pin_oe    (trigger_port_one_oe),
    .in_state  (st_one),
    .step_up   (up_one),
    .step_down (dn_one)
  );

  trig_port u_port_two (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .mode      (mode_two),
    .pol_low   (trig_cfg_reg[TRIG_PORT_SPAN + TRIG_POL_BIT]),
    .out_level (dig_out_reg[1]),
    .pin_in    (trigger_port_two_in),
    .pin_out   (trigger_port_two_out),
    .pin_oe    (trigger_port_two_oe),
    .in_state  (st_two),
    .step_up   (up_two),
    .step_down (dn_two)
  );

  // Steps apply only in open loop; up and down may cancel
  wire [1:0]  n_up   = open_loop ? {1'b0, up_one} + {1'b0, up_two} : 2'b00;
  wire [1:0]  n_dn   = open_loop ? {1'b0, dn_one} + {1'b0, dn_two} : 2'b00;
  wire [16:0] up_amt = (n_up == 2'h2) ? {step_reg, 1'b0} : (n_up[0] ? {1'b0, step_reg} : 17'h0);
  wire [16:0] dn_amt = (n_dn == 2'h2) ? {step_reg, 1'b0} : (n_dn[0] ? {1'b0, step_reg} : 17'h0);
  wire [17:0] drv_sum = {2'b00, drive_reg} + {1'b0, up_amt};
  wire [17:0] drv_sub = drv_sum - {1'b0, dn_amt};
  // Underflow clamps to zero, overflow to full scale unless the sum reaches bit 17, which also clamps to zero
  wire [15:0] drv_new = drv_sub[17] ? 16'h0000 : (|drv_sub[16] ? 16'hFFFF : drv_sub[15:0]);

  // ----------------------------------------------------------------
  // Configuration registers and persistence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trig_cfg_reg  <= TRIG_CFG_RST;
      step_reg      <= STEP_RST;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_done_reg <= 1'b1;
      // One-time load at the first edge after reset; a write in that cycle is lost
      if (nv_valid && !host_boot) begin
        trig_cfg_reg <= nv_trig_cfg;
        step_reg     <= nv_step;
      end
    end else begin
      if (wr_trig) trig_cfg_reg <= wdat16;
      if (wr_step) step_reg <= wdat16;
    end
  end

  // Persist strobe captures current wheel and trigger settings
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_write_reg <= 1'b0;
    end else begin
      nv_write_reg <= wr_pers;
    end
  end

  // Host output levels and display settings
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dig_out_reg <= 2'b00;
      active_reg  <= ACTIVE_RST;
      idle_reg    <= IDLE_RST;
      timeout_reg <= TIMEOUT_RST;
    end else begin
      if (wr_dout) dig_out_reg <= wb_dat_i[1:0];
      // Out-of-range display fields are clamped to their limits
      if (wr_disp && wb_sel_i[0])
        active_reg <= 7'(clamp9({2'b00, wb_dat_i[DISP_ACTIVE_LSB +: 7]},
                                {2'b00, BRIGHT_MAX}));
      if (wr_disp && wb_sel_i[1])
        idle_reg <= 4'(clamp9({5'h00, wb_dat_i[DISP_IDLE_LSB +: 4]},
                              {5'h00, IDLE_MAX}));
      if (wr_disp && wb_sel_i[2])
        timeout_reg <= clamp9(wb_dat_i[DISP_TIMEOUT_LSB +: 9], TIMEOUT_MAX);
    end
  end

  // Drive voltage accumulator
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drive_reg <= DRIVE_RST;
    end else if (wr_drive) begin
      drive_reg <= wdat16;
    end else begin
      drive_reg <= drv_new;
    end
  end

  // ----------------------------------------------------------------
  // Display dimming
  // ----------------------------------------------------------------
  wire activity  = panel_activity | menu_key;
  wire menu_rise = menu_key & ~menu_prev_reg;
  wire min_tick  = (tick_cnt_reg == 33'(MINUTE_CYCLES_P - 1));
  // At-or-beyond compare: a timeout lowered below the elapsed minutes still expires
  wire expire    = (timeout_reg != 9'h000) & min_tick & (min_cnt_reg >= timeout_reg - 9'h001);
  wire [6:0] idle_lvl = ({3'h0, idle_reg} < active_reg) ? {3'h0, idle_reg} : active_reg;
  wire [6:0] disp_next = (active_reg == 7'h00) ? (wake_reg ? BRIGHT_MIN_LIT : 7'h00)
                       : (dimmed_reg ? idle_lvl : active_reg);

  // Minute divider and minute counter restart on activity
  // Counting stops while dimmed or while dimming is off
  always_ff @(posedge sys_clk) begin
    if (reset || activity || timeout_reg == 9'h000 || dimmed_reg) begin
      tick_cnt_reg <= 33'h0;
      min_cnt_reg  <= 9'h000;
    end else if (min_tick) begin
      tick_cnt_reg <= 33'h0;
      min_cnt_reg  <= min_cnt_reg + 9'h001;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 33'h1;
    end
  end

  // Dim state, menu wake and shown level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      dimmed_reg    <= 1'b0;
      wake_reg      <= 1'b0;
      menu_prev_reg <= 1'b0;
      disp_reg      <= 7'h00;
    end else begin
      menu_prev_reg <= menu_key;
      // Activity wins over an expiry in the same cycle
      if (activity || timeout_reg == 9'h000) dimmed_reg <= 1'b0;
      else if (expire) dimmed_reg <= 1'b1;
      // Wake holds until the panel is back on position view with the key released
      if (menu_rise && active_reg == 7'h00) wake_reg <= 1'b1;
      else if (position_view && !menu_key) wake_reg <= 1'b0;
      disp_reg <= disp_next;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Status bits read zero outside digital input mode
  wire [31:0] status_word = {30'h0, st_two, st_one};
  // Persist register and unmapped offsets read zero
  wire [31:0] rd_mux =
      (wb_adr_i == ADDR_TRIG_CFG) ? {16'h0, trig_cfg_reg} :
      (wb_adr_i == ADDR_DIG_OUT)  ? {30'h0, dig_out_reg} :
      (wb_adr_i == ADDR_STATUS)   ? status_word :
      (wb_adr_i == ADDR_DISP_CFG) ? {7'h0, timeout_reg, 4'h0, idle_reg, 1'b0, active_reg} :
      (wb_adr_i == ADDR_STEP)     ? {16'h0, step_reg} :
      (wb_adr_i == ADDR_DRIVE)    ? {16'h0, drive_reg} : 32'h0;

  // One wait state ack, unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg   <= bus_req;
      if (bus_req) rdata_reg <= rd_mux;
    end
  end

  assign wb_ack_o        = ack_reg;
  assign wb_dat_o        = rdata_reg;
  assign nv_write        = nv_write_reg;
  assign nv_trig_cfg_out = trig_cfg_reg;
  assign nv_step_out     = step_reg;
  assign drive_level     = drive_reg;
  assign disp_level      = disp_reg;
  assign disp_dimmed     = dimmed_reg;
endmodule

// File: design/trig_port.sv
// One trigger port: synchroniser, polarity, edge detect and pin drive
`timescale 1ns/1ns
module trig_port
  import trig_disp_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire trig_disp_pkg::trig_mode_t mode,
  input  wire logic                      pol_low,
  input  wire logic                      out_level,
  input  wire logic                      pin_in,
  output logic                           pin_out,
  output logic                           pin_oe,
  output logic                           in_state,
  output logic                           step_up,
  output logic                           step_down
);
  import trig_disp_pkg::*;

  logic sync1_reg;
  logic sync2_reg;
  logic act_prev_reg;
  logic out_reg;
  logic oe_reg;
  logic state_reg;

  // Active level after polarity handling
  wire act_now  = sync2_reg ^ pol_low;
  // Inactive to active transition only
  wire act_rise = act_now & ~act_prev_reg;
  wire is_up    = (mode == TRIG_STEP_UP);
  wire is_down  = (mode == TRIG_STEP_DOWN);

  // Two stage synchroniser
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Edge memory and reported input state
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      act_prev_reg <= 1'b1; // Idle pull-up reads active at reset polarity: no false edge
      state_reg    <= 1'b0;
    end else begin
      act_prev_reg <= act_now;
      state_reg    <= (mode == TRIG_DIG_IN) ? sync2_reg : 1'b0;
    end
  end

  // Pin drive: only in output mode, active level per polarity
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      oe_reg  <= (mode == TRIG_DIG_OUT);
      out_reg <= out_level ^ pol_low;
    end
  end

  assign pin_out   = out_reg;
  assign pin_oe    = oe_reg;
  assign in_state  = state_reg;
  assign step_up   = is_up & act_rise;
  assign step_down = is_down & act_rise;
endmodule

// File: sim/tb.sv
// Self-checking bench for the trigger and display block
`timescale 1ns/1ns
module tb;
  import trig_disp_pkg::*;
  logic sys_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat, wb_rdat;
  logic p1, p2, o1, o2, e1, e2, eq1_en, eq1_val, eq2_en, eq2_val;
  logic open_loop, host_boot, menu_key, panel_activity, position_view, nv_valid, nv_write;
  logic nv_seen;
  logic [15:0] nv_cfg_o, nv_step_o, drive_level;
  logic [6:0]  disp_level;
  logic        disp_dimmed;
  int errors, checks_done;
  trig_disp_top #(.MINUTE_CYCLES_P(10)) i_trig_disp_top (.sys_clk(sys_clk), .reset(reset),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .trigger_port_one_in(p1),
    .trigger_port_one_out(o1), .trigger_port_one_oe(e1), .trigger_port_two_in(p2),
    .trigger_port_two_out(o2), .trigger_port_two_oe(e2), .open_loop(open_loop),
    .host_boot(host_boot), .menu_key(menu_key), .panel_activity(panel_activity),
    .position_view(position_view), .nv_valid(nv_valid), .nv_trig_cfg(16'h0401),
    .nv_step(16'h0007), .nv_write(nv_write), .nv_trig_cfg_out(nv_cfg_o),
    .nv_step_out(nv_step_o), .drive_level(drive_level), .disp_level(disp_level),
    .disp_dimmed(disp_dimmed));
  trig_equip i_trig_equip_one (.drv_en(eq1_en), .drv_val(eq1_val), .dut_oe(e1), .dut_out(o1),
    .pin(p1));
  trig_equip i_trig_equip_two (.drv_en(eq2_en), .drv_val(eq2_val), .dut_oe(e2), .dut_out(o2),
    .pin(p2));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Sticky flag for the store pulse
  always @(posedge sys_clk) begin
    if (reset) nv_seen <= 1'b0;
    else if (nv_write === 1'b1) nv_seen <= 1'b1;
  end
  task automatic test_done();
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Classic single cycle: hold until ack is sampled, then release for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    if (wb_ack !== 1'b1) begin
      chk("wb_ack", 32'h1, 32'(wb_ack));
      test_done();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic do_reset(input logic nv, input logic hb);
    nv_valid  <= nv;
    host_boot <= hb;
    reset     <= 1'b1;
    tick(5);
    reset <= 1'b0;
    tick(2);
  endtask
  task automatic pulse_activity();
    panel_activity <= 1'b1;
    tick(1);
    panel_activity <= 1'b0;
  endtask
  task automatic wait_dim();
    int n;
    n = 0;
    while (disp_dimmed !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk("disp_dimmed", 32'h1, 32'(disp_dimmed));
    if (disp_dimmed !== 1'b1) test_done();
    tick(2);
  endtask
  task automatic t_regs();
    rd(ADDR_TRIG_CFG, 32'h0, "trig_cfg");
    rd(ADDR_DISP_CFG, 32'h000A023C, "disp_cfg");
    rd(ADDR_STEP, 32'h1, "step");
    rd(8'h1C, 32'h0, "unmapped");
    chk("disp_level", 32'd60, 32'(disp_level));
    wr(ADDR_DISP_CFG, 32'h01FF0F7F);
    rd(ADDR_DISP_CFG, 32'h01E00A64, "disp_clamp");
    chk("disp_max", 32'd100, 32'(disp_level));
  endtask
  task automatic t_digio();
    wr(ADDR_TRIG_CFG, 32'h000C);
    tick(1);
    chk("oe1_on", 32'h1, 32'(e1));
    chk("out1_idle", 32'h1, 32'(o1));
    wr(ADDR_TRIG_CFG, 32'h0401);
    wr(ADDR_DIG_OUT, 32'h2);
    tick(2);
    chk("oe2", 32'h1, 32'(e2));
    chk("out2", 32'h1, 32'(o2));
    chk("oe1", 32'h0, 32'(e1));
    eq1_en  <= 1'b1;
    eq1_val <= 1'b0;
    tick(4);
    rd(ADDR_STATUS, 32'h0, "status_low");
    eq1_en <= 1'b0;
    tick(4);
    rd(ADDR_STATUS, 32'h1, "status_high");
    wr(ADDR_TRIG_CFG, 32'h0C00);
    tick(2);
    chk("out2_low", 32'h0, 32'(o2));
    chk("oe1_off", 32'h0, 32'(e1));
    rd(ADDR_STATUS, 32'h0, "status_off");
  endtask
  task automatic t_steps();
    open_loop <= 1'b1;
    eq1_en    <= 1'b1;
    eq1_val   <= 1'b0;
    wr(ADDR_STEP, 32'h5);
    wr(ADDR_DRIVE, 32'd100);
    wr(ADDR_TRIG_CFG, 32'h0B02);
    tick(4);
    chk("drive_idle", 32'd100, 32'(drive_level));
    eq1_val <= 1'b1;
    tick(6);
    chk("drive_up", 32'd105, 32'(drive_level));
    tick(6);
    chk("drive_held", 32'd105, 32'(drive_level));
    eq1_val <= 1'b0;
    tick(6);
    chk("drive_fall", 32'd105, 32'(drive_level));
    eq2_en  <= 1'b1;
    eq2_val <= 1'b0;
    tick(6);
    chk("drive_down", 32'd100, 32'(drive_level));
    eq2_val   <= 1'b1;
    open_loop <= 1'b0;
    tick(4);
    eq1_val <= 1'b1;
    tick(6);
    chk("drive_closed", 32'd100, 32'(drive_level));
    open_loop <= 1'b1;
  endtask
  task automatic t_display();
    wr(ADDR_DISP_CFG, 32'h00010528);
    pulse_activity();
    tick(5);
    chk("dim_early", 32'h0, 32'(disp_dimmed));
    wait_dim();
    chk("dim_level", 32'd5, 32'(disp_level));
    pulse_activity();
    tick(3);
    chk("wake_level", 32'd40, 32'(disp_level));
    wr(ADDR_DISP_CFG, 32'h00010503);
    wait_dim();
    chk("dim_min", 32'd3, 32'(disp_level));
    wr(ADDR_DISP_CFG, 32'h00000528);
    pulse_activity();
    tick(40);
    chk("no_dim", 32'h0, 32'(disp_dimmed));
    wr(ADDR_DISP_CFG, 32'h00000500);
    position_view <= 1'b0;
    menu_key      <= 1'b1;
    tick(1);
    menu_key <= 1'b0;
    tick(3);
    chk("menu_lit", 32'(BRIGHT_MIN_LIT), 32'(disp_level));
    position_view <= 1'b1;
    tick(3);
    chk("menu_off", 32'h0, 32'(disp_level));
  endtask
  task automatic t_persist();
    wr(ADDR_STEP, 32'h33);
    chk("nv_idle", 32'h0, 32'(nv_seen));
    wr(ADDR_PERSIST, 32'h1);
    tick(2);
    chk("nv_write", 32'h1, 32'(nv_seen));
    chk("nv_step", 32'h33, 32'(nv_step_o));
    chk("nv_cfg", 32'h0B02, 32'(nv_cfg_o));
    do_reset(1'b1, 1'b0);
    rd(ADDR_TRIG_CFG, 32'h0401, "boot_cfg");
    rd(ADDR_STEP, 32'h7, "boot_step");
    do_reset(1'b1, 1'b1);
    rd(ADDR_TRIG_CFG, 32'h0, "host_cfg");
    rd(ADDR_STEP, 32'h1, "host_step");
  endtask
  initial begin
    {reset, wb_cyc, wb_stb, wb_we, eq1_en, eq1_val, eq2_en, eq2_val} = 8'h80;
    {open_loop, host_boot, menu_key, panel_activity, nv_valid} = 5'h00;
    position_view = 1'b1;
    wb_adr = 8'h00;
    wb_dat = 32'h0;
    errors = 0;
    checks_done = 0;
    do_reset(1'b0, 1'b0);
    t_regs();
    t_digio();
    t_steps();
    t_display();
    t_persist();
    test_done();
  end
endmodule
bind trig_disp_top trig_disp_asserts #(.MINUTE_CYCLES_P(MINUTE_CYCLES_P)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .trigger_port_one_oe(trigger_port_one_oe),
  .trigger_port_two_oe(trigger_port_two_oe), .open_loop(open_loop),
  .panel_activity(panel_activity), .nv_write(nv_write), .drive_level(drive_level),
  .disp_level(disp_level), .disp_dimmed(disp_dimmed));

// File: sim/trig_disp_asserts.sv
// Port-level assertions for the trigger and display block
`timescale 1ns/1ns
module trig_disp_asserts
  import trig_disp_pkg::*;
#(
  parameter longint MINUTE_CYCLES_P = 10
)
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic        wb_ack_o,
  input wire logic        trigger_port_one_oe,
  input wire logic        trigger_port_two_oe,
  input wire logic        open_loop,
  input wire logic        panel_activity,
  input wire logic        nv_write,
  input wire logic [15:0] drive_level,
  input wire logic [6:0]  disp_level,
  input wire logic        disp_dimmed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // A write request is on the bus
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i;
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_oe_by_write: assert property ($changed({trigger_port_one_oe, trigger_port_two_oe}) |->
    $past(wr) || $past(wr, 2) || $past(reset) || $past(reset, 2) || $past(reset, 3))
    else $error("pin enable changed without config write");
  a_drive_open: assert property ($changed(drive_level) |->
    $past(wr) || $past(wr, 2) || $past(open_loop)) else $error("drive moved in closed loop");
  a_disp_max: assert property (disp_level <= BRIGHT_MAX) else $error("brightness above max");
  a_dim_level: assert property (disp_dimmed && $past(disp_dimmed) |->
    disp_level <= 7'(IDLE_MAX)) else $error("dimmed level above idle max");
  a_wake_restore: assert property (panel_activity |-> ##[1:2] !disp_dimmed)
    else $error("activity did not undim");
  a_nv_cause: assert property (nv_write |-> $past(wr) || $past(wr, 2))
    else $error("store pulse without write");
  c_nv: cover property (nv_write);
  c_dim: cover property ($rose(disp_dimmed));
  c_step: cover property ($changed(drive_level) && open_loop);
endmodule

// File: sim/trig_equip.sv
// External equipment on one trigger line, with the line's weak pull-up
`timescale 1ns/1ns
module trig_equip (
  input  wire logic drv_en,
  input  wire logic drv_val,
  input  wire logic dut_oe,
  input  wire logic dut_out,
  output logic      pin
);
  // Pull-up wins when neither side drives the line
  assign pin = dut_oe ? dut_out : (drv_en ? drv_val : 1'b1);
endmodule
